// *** pac_pkg.sv ***
// How it works
// R1: Every stage's result is examined on each conversion for an approaching user.
// R2: Proximity on a stage stops its ambient calibration at once.
// R3: Disable lasts fp count conversions, or lp count times 4 plus wake.
// R4: Calibration resumes after the period only if proximity has cleared.
// R5: Lasting proximity forces a recalibration after the recal count conversions.
// R6: A forced recalibration occupies the stage for two conversions.
// R7: Host must not access registers while a forced recalibration runs.
// R8: Approach flag when newest and oldest history words differ beyond threshold.
// R9: Hover flag when fast average and ambient differ beyond hover threshold.
// R10: The hover comparator also catches an ambient shift left by the user.
// R11: Slow filter enables on a large history step, only without proximity.
// R12: Slow ambient filter updates only when enabled and no proximity.
// R13: Ambient compensation runs on every conversion while untouched; the code updates it in tracking only when the slow filter is enabled.
// R14: Drift moves each stage's upper and lower offset levels.
// R15: Ambient is learned only with no approach or contact; the code's forced recal sets it to the fast average under proximity.
// R16: Per-stage compensation and setup data live in internal storage.
// R17: Interrupt pin asserts while a result lies beyond its offset levels.
// R18: Calibration-disable counts are 4-bit fields at address 0x002.
// R19: Recal counts are 8-bit and 6-bit fields at address 0x004.
// R20: Wake interval codes 00..11 give 100, 200, 300, 400 ms.
// R21: Every stage keeps its own proximity and timing state.
package pac_pkg;
   localparam int unsigned PAC_NUM_STAGES = 12;
   localparam int unsigned PAC_DW         = 16;
   // Register addresses
   localparam logic [7:0] PAC_ADDR_CTRL   = 8'h00;
   localparam logic [7:0] PAC_ADDR_CALDIS = 8'h02;
   localparam logic [7:0] PAC_ADDR_LEVELS = 8'h03;
   localparam logic [7:0] PAC_ADDR_RECAL  = 8'h04;
   localparam logic [7:0] PAC_ADDR_PROX   = 8'h0E;
   localparam logic [7:0] PAC_ADDR_STATUS = 8'h0F;
   localparam logic [7:0] PAC_ADDR_OFS    = 8'h10;
   localparam logic [7:0] PAC_ADDR_OFS_END = 8'h28;
   // Field positions
   localparam int unsigned PAC_WAKE_LSB    = 2;
   localparam int unsigned PAC_FPCNT_LSB   = 0;
   localparam int unsigned PAC_LPCNT_LSB   = 4;
   localparam int unsigned PAC_STEP_LSB    = 8;
   localparam int unsigned PAC_HOVER_LSB   = 0;
   localparam int unsigned PAC_APPR_LSB    = 8;
   localparam int unsigned PAC_FPRECAL_LSB = 0;
   localparam int unsigned PAC_LPRECAL_LSB = 8;
   localparam int unsigned PAC_ST_ANYPROX  = 0;
   localparam int unsigned PAC_ST_BUSY     = 1;
   localparam int unsigned PAC_ST_IRQPIN   = 2;
   // Reset values
   localparam logic [15:0] PAC_RST_CTRL   = 16'h0000;
   localparam logic [15:0] PAC_RST_CALDIS = 16'h0000;
   localparam logic [15:0] PAC_RST_LEVELS = 16'h0000;
   localparam logic [15:0] PAC_RST_RECAL  = 16'h0000;
   localparam logic [15:0] PAC_RST_UPPER  = 16'hFFFF;
   localparam logic [15:0] PAC_RST_LOWER  = 16'h0000;
   // Timing
   localparam int unsigned PAC_CLK_NS      = 10;
   localparam int unsigned PAC_MS_NS       = 1_000_000;
   localparam int unsigned PAC_MS_CYCLES_DEF = PAC_MS_NS / PAC_CLK_NS;
   localparam int unsigned PAC_MS_DIV_W    = 17;
   localparam logic [8:0]  PAC_WAKE_STEP_MS = 9'd100;
   localparam logic [7:0]  PAC_RECAL_CONV  = 8'd2;
   localparam int unsigned PAC_SLOW_SHIFT  = 2;

   typedef enum logic [1:0] {
      PAC_TRACK,
      PAC_CALDIS,
      PAC_WAKE,
      PAC_RECAL
   } pac_mode_t;

   typedef struct packed {
      pac_mode_t        mode;
      logic             seeded;
      logic             prox;
      logic             touch;
      logic [3:0][15:0] hist;
      logic [15:0]      amb;
      logic [15:0]      upLvl;
      logic [15:0]      loLvl;
      logic [7:0]       cnt;
      logic [7:0]       proxDur;
      logic [8:0]       msLeft;
   } pac_stage_t;
endpackage

// *** pac_calib.sv ***
`timescale 1ns/10ps
module pac_calib import pac_pkg::*; #(
   parameter int unsigned MS_CYCLES = PAC_MS_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // Conversion result stream
   input  wire logic        resultValid,
   input  wire logic [3:0]  resultStage,
   input  wire logic [15:0] resultData,
   input  wire logic        lowPowerMode,
   // Register port
   input  wire logic [7:0]  regAddr,
   input  wire logic        regWrEn,
   input  wire logic [15:0] regWrData,
   input  wire logic        regRdEn,
   output logic [15:0]      regRdData,
   // Status
   output logic             recalBusy,
   output logic [11:0]      proxFlags,
   // Interrupt pin, open drain
   input  wire logic        hostIrqNIn,
   output logic             hostIrqNOut,
   output logic             hostIrqNOe
);

   typedef struct packed {
      logic [15:0]                          ctrl;
      logic [15:0]                          caldis;
      logic [15:0]                          levels;
      logic [15:0]                          recal;
      pac_stage_t [PAC_NUM_STAGES-1:0]      stg;
      logic [PAC_MS_DIV_W-1:0]              msDiv;
      logic [2:0]                           irqSync;
      logic                                 irqLvl;
      logic                                 irqOe;
      logic                                 busy;
      logic [15:0]                          rdData;
   } pac_state_t;

   pac_state_t  q;
   pac_state_t  n;
   pac_stage_t  s;
   logic [17:0] sum;
   logic [15:0] avg;
   logic [15:0] dNew;
   logic [15:0] dAmb;
   logic [15:0] step;
   logic signed [16:0] drift;
   logic signed [16:0] delta;
   logic        p1;
   logic        p2;
   logic        prox;
   logic        slowEn;
   logic        msTick;
   logic [7:0]  calLim;
   logic [7:0]  recalLim;
   logic [3:0]  ofsIdx;
   logic [7:0]  ofsOff;

   function automatic logic [15:0] absDiff(input logic [15:0] a,
                                            input logic [15:0] b);
      absDiff = (a > b) ? a - b : b - a;
   endfunction

   // Levels saturate: a window left wide open at all ones or all zeros
   // must not wrap round into a false touch when drift is added
   function automatic logic [15:0] satAdd(input logic [15:0]        a,
                                          input logic signed [16:0] d);
      logic signed [17:0] t;
      t = signed'({2'b00, a}) + signed'({d[16], d});
      if (t < 18'sh0_0000) begin
         satAdd = 16'h0000;
      end else if (t > 18'sh0_FFFF) begin
         satAdd = 16'hFFFF;
      end else begin
         satAdd = t[15:0];
      end
   endfunction

   always_comb begin
      n        = q;
      s        = q.stg[0];
      sum      = 18'h0_0000;
      avg      = 16'h0000;
      dNew     = 16'h0000;
      dAmb     = 16'h0000;
      step     = 16'h0000;
      drift    = 17'sh0_0000;
      delta    = 17'sh0_0000;
      p1       = 1'b0;
      p2       = 1'b0;
      prox     = 1'b0;
      slowEn   = 1'b0;
      ofsOff   = regAddr - PAC_ADDR_OFS;
      ofsIdx   = ofsOff[4:1];

      // Counts for this power mode
      calLim   = lowPowerMode ?
                 {2'b00, q.caldis[PAC_LPCNT_LSB +: 4], 2'b00} :
                 {4'h0, q.caldis[PAC_FPCNT_LSB +: 4]};  // R3 R18
      recalLim = lowPowerMode ?
                 {2'b00, q.recal[PAC_LPRECAL_LSB +: 6]} :
                 q.recal[PAC_FPRECAL_LSB +: 8];  // R5 R19

      // Millisecond time base for the low-power wake interval
      msTick  = (q.msDiv == PAC_MS_DIV_W'(MS_CYCLES - 1));
      n.msDiv = msTick ? '0 : q.msDiv + 1'b1;
      for (int i = 0; i < PAC_NUM_STAGES; i++) begin
         if (q.stg[i].mode == PAC_WAKE && msTick) begin
            if (q.stg[i].msLeft <= 9'd1) begin
               n.stg[i].mode = PAC_TRACK;  // R3
            end else begin
               n.stg[i].msLeft = q.stg[i].msLeft - 9'd1;
            end
         end
      end

      // One result updates only its own stage
      if (resultValid && resultStage < 4'(PAC_NUM_STAGES)) begin  // R1 R21
         s = n.stg[resultStage];
         if (!s.seeded) begin
            // First result seeds history and ambient so no false proximity
            s.hist   = {4{resultData}};
            s.amb    = resultData;
            s.seeded = 1'b1;
         end else begin
            s.hist = {s.hist[2:0], resultData};
            sum    = 18'(s.hist[0]) + 18'(s.hist[1])
                   + 18'(s.hist[2]) + 18'(s.hist[3]);
            avg    = sum[17:2];
            dNew   = absDiff(s.hist[0], s.hist[3]);
            dAmb   = absDiff(avg, s.amb);
            s.touch = resultData > s.upLvl || resultData < s.loLvl;  // R17
            p1     = dNew > {10'h000, q.levels[PAC_APPR_LSB +: 6]};  // R8
            p2     = dAmb > {8'h00, q.levels[PAC_HOVER_LSB +: 8]};  // R9 R10
            prox   = p1 || p2 || s.touch;
            slowEn = dNew > {8'h00, q.caldis[PAC_STEP_LSB +: 8]}
                     && !prox;  // R11
            delta  = signed'(17'(avg)) - signed'(17'(s.amb));
            drift  = delta >>> PAC_SLOW_SHIFT;
            step   = 16'(drift);
            s.prox = prox;
            case (s.mode)
               PAC_TRACK: begin
                  if (prox) begin
                     s.mode    = PAC_CALDIS;  // R2
                     s.cnt     = calLim;  // R3
                     s.proxDur = 8'h00;
                  end else if (slowEn) begin
                     // Levels follow the ambient so the window keeps its size
                     s.amb   = s.amb + step;  // R12 R13 R15
                     s.upLvl = satAdd(s.upLvl, drift);  // R14
                     s.loLvl = satAdd(s.loLvl, drift);  // R14
                  end
               end
               PAC_CALDIS: begin
                  s.proxDur = prox ? s.proxDur + 8'h01 : 8'h00;
                  if (prox && recalLim != 8'h00
                      && s.proxDur >= recalLim) begin
                     s.mode = PAC_RECAL;  // R5
                     s.cnt  = PAC_RECAL_CONV;  // R6
                  end else if (s.cnt > 8'h01) begin
                     s.cnt = s.cnt - 8'h01;  // R3
                  end else if (prox) begin
                     s.cnt = calLim;  // R4
                  end else if (lowPowerMode) begin
                     s.mode   = PAC_WAKE;  // R3
                     s.msLeft = PAC_WAKE_STEP_MS
                              * {7'h00, q.ctrl[PAC_WAKE_LSB +: 2]}
                              + PAC_WAKE_STEP_MS;  // R20
                  end else begin
                     s.mode = PAC_TRACK;  // R4
                  end
               end
               PAC_WAKE: begin
                  if (prox) begin
                     s.mode    = PAC_CALDIS;  // R4
                     s.cnt     = calLim;
                     s.proxDur = 8'h00;
                  end
               end
               default: begin
                  // Forced recalibration takes the fast average as ambient
                  s.amb   = avg;  // R6 R10
                  s.upLvl = satAdd(s.upLvl, delta);  // R14
                  s.loLvl = satAdd(s.loLvl, delta);  // R14
                  if (s.cnt > 8'h01) begin
                     s.cnt = s.cnt - 8'h01;  // R6
                  end else begin
                     s.mode    = PAC_TRACK;
                     s.proxDur = 8'h00;
                  end
               end
            endcase
         end
         n.stg[resultStage] = s;  // R16
      end

      // Register writes; host setup wins over the same-cycle update
      if (regWrEn) begin
         if (regAddr == PAC_ADDR_CTRL) begin
            n.ctrl = regWrData;
         end else if (regAddr == PAC_ADDR_CALDIS) begin
            n.caldis = regWrData;  // R18
         end else if (regAddr == PAC_ADDR_LEVELS) begin
            n.levels = regWrData;
         end else if (regAddr == PAC_ADDR_RECAL) begin
            n.recal = regWrData;  // R19
         end else if (regAddr >= PAC_ADDR_OFS
                      && regAddr < PAC_ADDR_OFS_END) begin
            if (ofsOff[0]) begin
               n.stg[ofsIdx].loLvl = regWrData;  // R16
            end else begin
               n.stg[ofsIdx].upLvl = regWrData;  // R16
            end
         end
      end

      // Status gathered from the next state
      n.busy  = 1'b0;
      n.irqOe = 1'b0;
      for (int i = 0; i < PAC_NUM_STAGES; i++) begin
         // Lets the host hold off its accesses while a stage recalibrates
         n.busy  = n.busy | (n.stg[i].mode == PAC_RECAL);  // R7
         n.irqOe = n.irqOe | n.stg[i].touch;  // R17
      end

      // Pin sampling: level accepted once the second and third stages agree
      n.irqSync = {q.irqSync[1:0], hostIrqNIn};
      if (q.irqSync[1] == q.irqSync[2]) begin
         n.irqLvl = q.irqSync[2];
      end

      // Register reads
      if (regRdEn) begin
         if (regAddr == PAC_ADDR_CTRL) begin
            n.rdData = q.ctrl;
         end else if (regAddr == PAC_ADDR_CALDIS) begin
            n.rdData = q.caldis;
         end else if (regAddr == PAC_ADDR_LEVELS) begin
            n.rdData = q.levels;
         end else if (regAddr == PAC_ADDR_RECAL) begin
            n.rdData = q.recal;
         end else if (regAddr == PAC_ADDR_PROX) begin
            n.rdData = {4'h0, proxFlags};
         end else if (regAddr == PAC_ADDR_STATUS) begin
            n.rdData = 16'h0000;
            n.rdData[PAC_ST_ANYPROX] = |proxFlags;
            n.rdData[PAC_ST_BUSY]    = q.busy;
            n.rdData[PAC_ST_IRQPIN]  = q.irqLvl;
         end else if (regAddr >= PAC_ADDR_OFS
                      && regAddr < PAC_ADDR_OFS_END) begin
            n.rdData = ofsOff[0] ? q.stg[ofsIdx].loLvl
                                 : q.stg[ofsIdx].upLvl;
         end else begin
            n.rdData = 16'h0000;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q.ctrl    <= PAC_RST_CTRL;
         q.caldis  <= PAC_RST_CALDIS;
         q.levels  <= PAC_RST_LEVELS;
         q.recal   <= PAC_RST_RECAL;
         for (int i = 0; i < PAC_NUM_STAGES; i++) begin
            q.stg[i].mode    <= PAC_TRACK;
            q.stg[i].seeded  <= 1'b0;
            q.stg[i].prox    <= 1'b0;
            q.stg[i].touch   <= 1'b0;
            q.stg[i].hist    <= '0;
            q.stg[i].amb     <= 16'h0000;
            q.stg[i].upLvl   <= PAC_RST_UPPER;
            q.stg[i].loLvl   <= PAC_RST_LOWER;
            q.stg[i].cnt     <= 8'h00;
            q.stg[i].proxDur <= 8'h00;
            q.stg[i].msLeft  <= 9'h000;
         end
         q.msDiv   <= '0;
         q.irqSync <= 3'b111;
         q.irqLvl  <= 1'b1;
         q.irqOe   <= 1'b0;
         q.busy    <= 1'b0;
         q.rdData  <= 16'h0000;
      end else begin
         q <= n;
      end
   end

   always_comb begin
      for (int i = 0; i < PAC_NUM_STAGES; i++) begin
         proxFlags[i] = q.stg[i].prox;
      end
   end

   assign regRdData   = q.rdData;
   assign recalBusy   = q.busy;
   assign hostIrqNOe  = q.irqOe;
   // Open drain: only ever pulls low
   assign hostIrqNOut = 1'b0;

endmodule

// *** pac_sensor_model.sv ***
`timescale 1ns/10ps
module pac_sensor_model import pac_pkg::*; (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // Command from the bench
   input  wire logic        go,
   input  wire logic [3:0]  goStage,
   input  wire logic [15:0] goData,
   // Conversion result stream
   output logic             resultValid,
   output logic [3:0]       resultStage,
   output logic [15:0]      resultData
);
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         resultValid <= 1'b0;
         resultStage <= 4'h0;
         resultData  <= 16'h0000;
      end else if (go) begin
         resultValid <= 1'b1;
         resultStage <= goStage;
         resultData  <= goData;
      end else begin
         // Stale data toggles so nothing can lean on a held value
         resultValid <= 1'b0;
         resultStage <= ~resultStage;
         resultData  <= ~resultData;
      end
   end
endmodule

// *** pac_calib_chk.sv ***
`timescale 1ns/10ps
module pac_calib_chk import pac_pkg::*; #(
   parameter int unsigned MS_CYCLES = PAC_MS_CYCLES_DEF
) (
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        resultValid,
   input wire logic [3:0]  resultStage,
   input wire logic [15:0] resultData,
   input wire logic        lowPowerMode,
   input wire logic [7:0]  regAddr,
   input wire logic        regWrEn,
   input wire logic [15:0] regWrData,
   input wire logic        regRdEn,
   input wire logic [15:0] regRdData,
   input wire logic        recalBusy,
   input wire logic [11:0] proxFlags,
   input wire logic        hostIrqNIn,
   input wire logic        hostIrqNOut,
   input wire logic        hostIrqNOe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic [11:0] keepMask;
   assign keepMask = ~(12'h001 << resultStage);
   sequence resTaken;
      resultValid && (resultStage < 4'hC);
   endsequence
   sequence wireSteady;
      $stable(hostIrqNIn) [*8];
   endsequence
   sequence statusRd;
      regRdEn && (regAddr == PAC_ADDR_STATUS);
   endsequence
   AST_OD_LOW: assert property (hostIrqNOut == 1'b0)
      else $error("irq out pin not low");
   AST_FLAGS_IDLE: assert property (!(resultValid && resultStage < 4'hC)
      |=> $stable(proxFlags)) else $error("flags moved without result");
   AST_FLAGS_OWN: assert property (resTaken |=> ((proxFlags &
      $past(keepMask)) == ($past(proxFlags) & $past(keepMask))))
      else $error("other stage flag moved");
   AST_OE_CAUSE: assert property ($changed(hostIrqNOe) |->
      $past(resultValid)) else $error("irq moved without result");
   AST_BUSY_CAUSE: assert property ($changed(recalBusy) |->
      $past(resultValid)) else $error("busy moved without result");
   AST_BUSY_PROX: assert property ($rose(recalBusy) |->
      (proxFlags != 12'h000)) else $error("recal without proximity");
   AST_RD_HOLD: assert property (!regRdEn |=> $stable(regRdData))
      else $error("read data not held");
   AST_UNMAPPED_ZERO: assert property (regRdEn && regAddr == 8'h01
      |=> regRdData == 16'h0000) else $error("unmapped read not zero");
   AST_PROX_READ: assert property (regRdEn && regAddr == PAC_ADDR_PROX
      |=> regRdData == {4'h0, $past(proxFlags)}) else $error("prox read");
   AST_STATUS_BITS: assert property (statusRd |=>
      (regRdData[PAC_ST_BUSY] == $past(recalBusy)) &&
      (regRdData[PAC_ST_ANYPROX] == |$past(proxFlags)))
      else $error("status bits");
   AST_IRQ_LEVEL: assert property ((wireSteady ##0 statusRd) |=>
      regRdData[PAC_ST_IRQPIN] == $past(hostIrqNIn))
      else $error("irq wire level in status");
endmodule
bind pac_calib pac_calib_chk #(.MS_CYCLES(MS_CYCLES)) i_pac_calib_chk (
   .core_clk(core_clk), .nrst(nrst), .resultValid(resultValid),
   .resultStage(resultStage), .resultData(resultData),
   .lowPowerMode(lowPowerMode), .regAddr(regAddr), .regWrEn(regWrEn),
   .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
   .recalBusy(recalBusy), .proxFlags(proxFlags), .hostIrqNIn(hostIrqNIn),
   .hostIrqNOut(hostIrqNOut), .hostIrqNOe(hostIrqNOe));

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench import pac_pkg::*; ;
   typedef struct packed {
      logic [7:0]  a;
      logic [15:0] r;
      logic [15:0] w;
      logic [15:0] e;
   } pac_row_t;
   // Address, reset value, value written, value read back
   localparam pac_row_t ROWS [8] = '{
      '{8'h00, 16'h0000, 16'h000C, 16'h000C},
      '{8'h02, 16'h0000, 16'hFFFF, 16'hFFFF},
      '{8'h03, 16'h0000, 16'hFFFF, 16'hFFFF},
      '{8'h04, 16'h0000, 16'hFFFF, 16'hFFFF},
      '{8'h01, 16'h0000, 16'hFFFF, 16'h0000},
      '{8'h0E, 16'h0000, 16'hFFFF, 16'h0000},
      '{8'h10, 16'hFFFF, 16'h0ABC, 16'h0ABC},
      '{8'h27, 16'h0000, 16'h1234, 16'h1234}};
   logic        core_clk, nrst, go, resultValid, regWrEn, regRdEn;
   logic        recalBusy, hostIrqNOut, hostIrqNOe, irqWire, lowPower;
   logic [3:0]  goStage, resultStage;
   logic [15:0] goData, resultData, regWrData, regRdData, rd;
   logic [7:0]  regAddr;
   logic [11:0] proxFlags;
   int          errors, testsRun;
   // Wire has a pull-up, the block only pulls it low
   assign irqWire = hostIrqNOe ? 1'b0 : 1'b1;
   pac_sensor_model i_pac_sensor_model (.core_clk(core_clk), .nrst(nrst),
      .go(go), .goStage(goStage), .goData(goData), .resultValid(resultValid),
      .resultStage(resultStage), .resultData(resultData));
   pac_calib #(.MS_CYCLES(4)) i_pac_calib (.core_clk(core_clk), .nrst(nrst),
      .resultValid(resultValid), .resultStage(resultStage),
      .resultData(resultData), .lowPowerMode(lowPower), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
      .regRdData(regRdData), .recalBusy(recalBusy), .proxFlags(proxFlags),
      .hostIrqNIn(irqWire), .hostIrqNOut(hostIrqNOut),
      .hostIrqNOe(hostIrqNOe));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      testsRun++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t value %h want %h", $time, got, exp);
      end
   endtask
   task automatic chkBit(input logic got, input logic exp);
      testsRun++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t flag %b want %b", $time, got, exp);
      end
   endtask
   task automatic regWr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge core_clk);
      regWrEn <= 1'b0;
      regWrData <= ~d;
   endtask
   task automatic regRd(input logic [7:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge core_clk);
      regRdEn <= 1'b0;
      @(negedge core_clk);
      rd = regRdData;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
      regRd(a);
      chk(rd, e);
   endtask
   task automatic conv(input logic [3:0] s, input logic [15:0] d);
      @(posedge core_clk);
      go <= 1'b1;
      goStage <= s;
      goData <= d;
      @(posedge core_clk);
      go <= 1'b0;
      @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic conclude;
      if (errors == 0 && testsRun > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      conclude();
   end
   initial begin
      nrst = 1'b0;
      lowPower = 1'b0;
      go = 1'b0;
      goStage = 4'h0;
      goData = 16'h0000;
      regAddr = 8'h00;
      regWrEn = 1'b0;
      regWrData = 16'h0000;
      regRdEn = 1'b0;
      errors = 0;
      testsRun = 0;
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      foreach (ROWS[i]) begin
         rdChk(ROWS[i].a, ROWS[i].r);
         regWr(ROWS[i].a, ROWS[i].w);
         rdChk(ROWS[i].a, ROWS[i].e);
      end
      // Approach comparator at its boundary, step 0, no forced recal
      regWr(PAC_ADDR_LEVELS, 16'h04FF);
      regWr(PAC_ADDR_CALDIS, 16'h0001);
      regWr(PAC_ADDR_RECAL, 16'h0000);
      conv(4'h1, 16'h07D0);
      conv(4'h1, 16'h07D4);
      chkBit(proxFlags[1], 1'b0);
      conv(4'h1, 16'h07D5);
      chkBit(proxFlags[1], 1'b1);
      conv(4'hC, 16'h0000);
      chk({4'h0, proxFlags}, 16'h0002);
      // Hover comparator: average drifts past a threshold of 2
      regWr(PAC_ADDR_LEVELS, 16'h3F02);
      conv(4'h6, 16'h03E8);
      conv(4'h6, 16'h03F2);
      chkBit(proxFlags[6], 1'b0);
      conv(4'h6, 16'h03F2);
      chkBit(proxFlags[6], 1'b1);
      // Slow filter moves both levels, then freezes under proximity
      regWr(PAC_ADDR_LEVELS, 16'h3FFF);
      regWr(8'h14, 16'h0FA0);
      regWr(8'h15, 16'h07D0);
      conv(4'h2, 16'h0BB8);
      conv(4'h2, 16'h0BE0);
      rdChk(8'h14, 16'h0FA2);
      rdChk(8'h15, 16'h07D2);
      regWr(PAC_ADDR_LEVELS, 16'h04FF);
      conv(4'h2, 16'h0C1C);
      chkBit(proxFlags[2], 1'b1);
      rdChk(8'h14, 16'h0FA2);
      // Touch above, inside, then below the offset levels
      regWr(8'h16, 16'h13EC);
      regWr(8'h17, 16'h1324);
      conv(4'h3, 16'h1388);
      conv(4'h3, 16'h1450);
      chkBit(hostIrqNOe, 1'b1);
      conv(4'h3, 16'h1388);
      chkBit(hostIrqNOe, 1'b0);
      conv(4'h3, 16'h12C0);
      chkBit(hostIrqNOe, 1'b1);
      repeat (8) @(posedge core_clk);
      regRd(PAC_ADDR_STATUS);
      chkBit(rd[PAC_ST_IRQPIN], 1'b0);
      // Lasting proximity: recal after two counted conversions
      regWr(PAC_ADDR_RECAL, 16'h0002);
      conv(4'h4, 16'h1770);
      // No register access while the stage may be recalibrating
      for (int i = 1; i <= 6; i++) begin
         conv(4'h4, 16'h1770 + 16'(i * 100));
         chkBit(recalBusy, (i == 3 || i == 4));
      end
      // Low power: disable for lp count times 4, then the 100 ms wake delay
      regWr(PAC_ADDR_CTRL, 16'h0000);
      regWr(PAC_ADDR_CALDIS, 16'h0010);
      regWr(PAC_ADDR_LEVELS, 16'h3FFF);
      regWr(8'h1A, 16'h1030);
      regWr(8'h1B, 16'h0FF0);
      lowPower <= 1'b1;
      conv(4'h5, 16'h1000);
      conv(4'h5, 16'h1038);
      chkBit(proxFlags[5], 1'b1);
      repeat (4) conv(4'h5, 16'h1000);
      conv(4'h5, 16'h1030);
      rdChk(8'h1A, 16'h1030);
      repeat (300) @(posedge core_clk);
      conv(4'h5, 16'h1030);
      rdChk(8'h1A, 16'h1030);
      repeat (150) @(posedge core_clk);
      conv(4'h5, 16'h1030);
      rdChk(8'h1A, 16'h1039);
      // Reset in mid-run clears flags, pin and levels
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk({4'h0, proxFlags}, 16'h0000);
      chkBit(hostIrqNOe, 1'b0);
      nrst <= 1'b1;
      rdChk(8'h14, 16'hFFFF);
      rdChk(PAC_ADDR_LEVELS, 16'h0000);
      conclude();
   end
endmodule
